/* include/swx_pkg.sv */
// Purpose: constants for the select-with-attention transfer sequencer
// Assumes: apb byte addresses, one 32-bit word per register
// Notes: message and phase encodings follow the scsi bus lines
package swx_pkg;
  typedef logic [3:0] swx_code_t;
  // command state codes
  localparam swx_code_t CODE_NONE = 4'h0;
  localparam swx_code_t CODE_CDB_START = 4'h3;
  localparam swx_code_t CODE_CDB_DONE = 4'h4;
  localparam swx_code_t CODE_DATA = 4'h5;
  localparam swx_code_t CODE_SDP = 4'h6;
  localparam swx_code_t CODE_DISC_MSG = 4'h7;
  localparam swx_code_t CODE_TGT_GONE = 4'h8;
  localparam swx_code_t CODE_RESEL = 4'h9;
  localparam swx_code_t CODE_ID_OK = 4'ha;
  localparam swx_code_t CODE_DATA_END = 4'hb;
  localparam swx_code_t CODE_STATUS = 4'hc;
  localparam swx_code_t CODE_CC = 4'hd;
  localparam swx_code_t CODE_LCC = 4'he;
  // bus phases as msg/cd/io
  localparam logic [2:0] PH_DATA_OUT = 3'h0;
  localparam logic [2:0] PH_DATA_IN = 3'h1;
  localparam logic [2:0] PH_STATUS = 3'h3;
  localparam logic [2:0] PH_MSG_IN = 3'h7;
  // message bytes
  localparam logic [7:0] MSG_CMD_DONE = 8'h00;
  localparam logic [7:0] MSG_SDP = 8'h02;
  localparam logic [7:0] MSG_RESTORE = 8'h03;
  localparam logic [7:0] MSG_DISC = 8'h04;
  localparam logic [7:0] MSG_LINKED = 8'h0a;
  localparam logic [7:0] MSG_LINKED_FLAG = 8'h0b;
  localparam int MSG_ID_BIT = 7;
  localparam int LUN_W = 3;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_FUNC = 8'h08;
  localparam logic [7:0] OFF_ERR = 8'h0c;
  localparam logic [7:0] OFF_LUN = 8'h10;
  // control fields
  localparam int CT_START = 0;
  localparam int CT_PAUSE = 1;
  localparam int CT_HOLD = 2;
  localparam int CT_DIR = 3;
  localparam int CT_TID = 4;
  localparam int CT_LUN = 8;
  // status fields
  localparam int ST_RUN = 4;
  localparam int ST_SDP = 8;
  // functional_irq_status bits
  localparam int FI_BUS = 0;
  localparam int FI_FC = 1;
  localparam int FI_SEL = 2;
  localparam int FI_RSL = 3;
  localparam int FI_DIS = 4;
  localparam int FI_W = 5;
  // error_irq_status bits
  localparam int EI_HALT = 0;
  localparam int EI_PE = 1;
  localparam int EI_LUN = 2;
  localparam int EI_W = 3;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_RUN, SEQ_PARKED} swx_seq_e;
endpackage

/* include/swx_eval_if.sv */
// Purpose: carries one phase/message verdict between sequencer and judge
// Assumes: purely combinational path
// Notes: none
interface swx_eval_if;
  import swx_pkg::*;
  logic [3:0] code;
  logic [2:0] phase;
  logic [7:0] msg;
  logic tc_zero;
  logic dir_in;
  logic [LUN_W-1:0] lun_ref;
  logic ok;
  logic [3:0] next_code;
  logic lun_ok;
  modport judge (input code, phase, msg, tc_zero, dir_in, lun_ref,
    output ok, next_code, lun_ok);
  modport seq (output code, phase, msg, tc_zero, dir_in, lun_ref,
    input ok, next_code, lun_ok);
endinterface

/* verilog/swx_judge.sv */
// Purpose: decides whether a new bus phase is legal in the current code
// Assumes: phase and message byte valid together
// Notes: combinational; not ok means a bus service stop
module swx_judge
  import swx_pkg::*;
(
  // verdict link
  swx_eval_if.judge ev
);
  function automatic logic data_match(input logic [2:0] ph,
    input logic dir_in);
    data_match = ph == (dir_in ? PH_DATA_IN : PH_DATA_OUT);
  endfunction

  logic st_ok;
  logic dat_ok;
  logic mi;

  assign st_ok = (ev.phase == PH_STATUS) && ev.tc_zero;
  assign dat_ok = data_match(ev.phase, ev.dir_in) && !ev.tc_zero;
  assign mi = ev.phase == PH_MSG_IN;
  assign ev.lun_ok = ev.msg[LUN_W-1:0] == ev.lun_ref;

  always_comb begin
    ev.ok = 1'b1;
    ev.next_code = ev.code;
    unique case (ev.code)
      CODE_CDB_DONE: begin
        if (st_ok) ev.next_code = CODE_STATUS;
        else if (dat_ok) ev.next_code = CODE_DATA;
        else if (mi && ev.msg == MSG_SDP) ev.next_code = CODE_SDP;
        else if (mi && ev.msg == MSG_DISC) ev.next_code = CODE_DISC_MSG;
        else ev.ok = 1'b0;
      end
      CODE_DATA: begin
        if (st_ok) ev.next_code = CODE_STATUS;
        else if (dat_ok) ev.next_code = CODE_DATA;
        else if (mi && ev.msg == MSG_SDP) ev.next_code = CODE_SDP;
        else ev.ok = 1'b0;
      end
      CODE_SDP: begin
        if (data_match(ev.phase, ev.dir_in)) ev.next_code = CODE_DATA;
        else if (mi && ev.msg == MSG_DISC) ev.next_code = CODE_DISC_MSG;
        else ev.ok = 1'b0;
      end
      CODE_RESEL: begin
        if (mi && ev.msg[MSG_ID_BIT]) ev.next_code = CODE_ID_OK;
        else ev.ok = 1'b0;
      end
      CODE_ID_OK: begin
        if (st_ok) ev.next_code = CODE_STATUS;
        else if (dat_ok) ev.next_code = CODE_DATA;
        else if (mi && ev.msg == MSG_RESTORE) ev.next_code = CODE_ID_OK;
        else ev.ok = 1'b0;
      end
      CODE_DATA_END: begin
        if (ev.phase == PH_STATUS) ev.next_code = CODE_STATUS;
        else if (mi && ev.msg == MSG_SDP) ev.next_code = CODE_SDP;
        else ev.ok = 1'b0;
      end
      CODE_STATUS: begin
        if (mi && ev.msg == MSG_CMD_DONE) ev.next_code = CODE_CC;
        else if (mi && (ev.msg == MSG_LINKED || ev.msg == MSG_LINKED_FLAG))
          ev.next_code = CODE_LCC;
        else ev.ok = 1'b0;
      end
      default: begin
        // codes 3, 7, 8, d, e: any new information phase is judged not ok
        ev.ok = 1'b0;
      end
    endcase
  end
endmodule

/* verilog/swx_term.sv */
// Purpose: apb-controlled termination sequencer, state codes 3 to e
// Assumes: bus core delivers one-cycle event pulses synchronous to sys_clk
// Notes: codes 0 to 2 belong to the selection logic elsewhere
//
// Our own choices: the APB register port and the placing of the registers.
module swx_term
  import swx_pkg::*;
#(
  parameter int ID_W = 3
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // bus core events
  input wire logic cdb_done,
  input wire logic cdb_len_err,
  input wire logic phase_new,
  input wire logic [2:0] phase_kind,
  input wire logic [7:0] msg_byte,
  input wire logic tc_zero,
  input wire logic data_done,
  input wire logic parity_err,
  input wire logic target_gone,
  input wire logic resel_seen,
  input wire logic [ID_W-1:0] resel_id,
  input wire logic picked_as_target,
  // sequencer status
  output logic seq_active,
  output logic [3:0] seq_code,
  output logic seq_halt
);
  if (ID_W < 1 || ID_W > 4) begin : g_chk
    $error("ID_W must be 1 to 4");
  end

  typedef struct packed {
    swx_seq_e seq;
    logic [3:0] code;
    logic ptr_saved;
    logic [FI_W-1:0] functional_irq_status;
    logic [EI_W-1:0] error_irq_status;
    logic hold;
    logic dir_in;
    logic [ID_W-1:0] tid;
    logic [LUN_W-1:0] lun;
    logic halt;
    logic [31:0] rdata;
  } swx_state_s;

  function automatic logic [7:0] merge_flags(input logic [7:0] old,
    input logic [7:0] set, input logic [7:0] clr);
    // a flag raised in the clearing cycle survives
    merge_flags = (old & ~clr) | set;
  endfunction

  swx_state_s s_reg;
  swx_state_s s_next;
  swx_eval_if ev();
  logic wr;
  logic rd_setup;
  logic addr_ok;
  logic pause_req;
  logic start_req;
  logic [7:0] fset;
  logic [7:0] eset;
  logic [7:0] fclr;
  logic [7:0] eclr;
  logic [7:0] fmerged;
  logic [7:0] emerged;
  logic live;

  swx_judge u_judge (
    .ev(ev.judge)
  );

  assign ev.code = s_reg.code;
  assign ev.phase = phase_kind;
  assign ev.msg = msg_byte;
  assign ev.tc_zero = tc_zero;
  assign ev.dir_in = s_reg.dir_in;
  assign ev.lun_ref = s_reg.lun;

  assign addr_ok = paddr == OFF_CTRL || paddr == OFF_STAT ||
    paddr == OFF_FUNC || paddr == OFF_ERR || paddr == OFF_LUN;
  assign wr = psel && penable && pwrite && addr_ok;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign start_req = wr && paddr == OFF_CTRL && pwdata[CT_START];
  assign pause_req = wr && paddr == OFF_CTRL && pwdata[CT_PAUSE];
  assign live = s_reg.seq != SEQ_IDLE;

  assign prdata = s_reg.rdata;
  assign seq_active = live;
  assign seq_code = s_reg.code;
  assign seq_halt = s_reg.halt;

  always_comb begin
    s_next = s_reg;
    s_next.halt = 1'b0;
    fset = 8'h00;
    eset = 8'h00;
    fclr = 8'h00;
    eclr = 8'h00;
    if (wr && paddr == OFF_FUNC) fclr = pwdata[7:0];
    if (wr && paddr == OFF_ERR) eclr = pwdata[7:0];
    if (live) begin
      if (pause_req && (s_reg.code == CODE_CDB_DONE ||
          s_reg.code == CODE_DATA || s_reg.code == CODE_SDP ||
          s_reg.code == CODE_TGT_GONE)) begin
        eset[EI_HALT] = 1'b1;
        s_next.halt = 1'b1;
        s_next.seq = SEQ_IDLE;
      end else if (s_reg.code == CODE_CDB_START) begin
        if (cdb_len_err || phase_new) begin
          fset[FI_BUS] = 1'b1;
          eset[EI_HALT] = 1'b1;
          s_next.seq = SEQ_IDLE;
        end else if (cdb_done) begin
          s_next.code = CODE_CDB_DONE;
        end
      end else if (s_reg.code == CODE_DATA && parity_err) begin
        eset[EI_PE] = 1'b1;
        eset[EI_HALT] = 1'b1;
        s_next.seq = SEQ_IDLE;
      end else if (s_reg.code == CODE_TGT_GONE) begin
        if (picked_as_target) begin
          fset[FI_SEL] = 1'b1;
          s_next.seq = SEQ_IDLE;
        end else if (resel_seen) begin
          if (s_reg.functional_irq_status[FI_DIS] || resel_id != s_reg.tid) begin
            fset[FI_RSL] = 1'b1;
            s_next.seq = SEQ_IDLE;
          end else begin
            s_next.code = CODE_RESEL;
            s_next.seq = SEQ_RUN;
          end
        end
      end else if (s_reg.code == CODE_DISC_MSG && target_gone) begin
        s_next.code = CODE_TGT_GONE;
        if (s_reg.hold) begin
          fset[FI_DIS] = 1'b1;
        end
        // parked either way so a later reselect is still judged
        s_next.seq = SEQ_PARKED;
      end else if (s_reg.code == CODE_CC && target_gone) begin
        fset[FI_FC] = 1'b1;
        s_next.seq = SEQ_IDLE;
      end else if (s_reg.code == CODE_DATA && data_done) begin
        s_next.code = CODE_DATA_END;
      end else if (phase_new) begin
        if (s_reg.code == CODE_RESEL && ev.ok && !ev.lun_ok) begin
          eset[EI_LUN] = 1'b1;
          s_next.lun = msg_byte[LUN_W-1:0];
          s_next.seq = SEQ_IDLE;
        end else if (ev.ok) begin
          s_next.code = ev.next_code;
          if (ev.next_code == CODE_SDP) s_next.ptr_saved = 1'b1;
          if (ev.next_code == CODE_LCC) fset[FI_FC] = 1'b1;
        end else begin
          fset[FI_BUS] = 1'b1;
          s_next.seq = SEQ_IDLE;
        end
      end
    end
    // code stays put once idle until software starts again
    if (start_req) begin
      s_next.seq = SEQ_RUN;
      s_next.code = CODE_CDB_START;
      s_next.ptr_saved = 1'b0;
      s_next.hold = pwdata[CT_HOLD];
      s_next.dir_in = pwdata[CT_DIR];
      s_next.tid = pwdata[CT_TID +: ID_W];
      s_next.lun = pwdata[CT_LUN +: LUN_W];
    end else if (wr && paddr == OFF_CTRL) begin
      s_next.hold = pwdata[CT_HOLD];
    end
    fmerged = merge_flags({{(8-FI_W){1'b0}}, s_reg.functional_irq_status}, fset, fclr);
    emerged = merge_flags({{(8-EI_W){1'b0}}, s_reg.error_irq_status}, eset, eclr);
    s_next.functional_irq_status = fmerged[FI_W-1:0];
    s_next.error_irq_status = emerged[EI_W-1:0];
    if (rd_setup) begin
      s_next.rdata = 32'h0000_0000;
      unique case (paddr)
        OFF_CTRL: begin
          s_next.rdata[CT_HOLD] = s_reg.hold;
          s_next.rdata[CT_DIR] = s_reg.dir_in;
          s_next.rdata[CT_TID +: ID_W] = s_reg.tid;
        end
        OFF_STAT: begin
          s_next.rdata[3:0] = s_reg.code;
          s_next.rdata[ST_RUN] = live;
          s_next.rdata[ST_SDP] = s_reg.ptr_saved;
        end
        OFF_FUNC: s_next.rdata[FI_W-1:0] = s_reg.functional_irq_status;
        OFF_ERR: s_next.rdata[EI_W-1:0] = s_reg.error_irq_status;
        OFF_LUN: s_next.rdata[LUN_W-1:0] = s_reg.lun;
        default: s_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) s_reg <= '0;
    else s_reg <= s_next;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sequence s_len_fault;
    live && s_reg.code == CODE_CDB_START && cdb_len_err && !start_req;
  endsequence
  sequence s_leave_nohold;
    live && s_reg.code == CODE_DISC_MSG && target_gone && !s_reg.hold &&
      !start_req && !pause_req;
  endsequence
  sequence s_parked_quiet;
    !resel_seen && !picked_as_target && !pause_req && !start_req &&
      !phase_new;
  endsequence

  property p_len_fault;
    s_len_fault |=> s_reg.functional_irq_status[FI_BUS] && s_reg.error_irq_status[EI_HALT] && !live;
  endproperty
  a_len_fault: assert property (p_len_fault)
    else $error("wrong length did not stop with bus and halt");

  property p_cdb_bad_phase;
    live && s_reg.code == CODE_CDB_DONE && phase_new && !ev.ok &&
      !pause_req && !start_req |=> s_reg.functional_irq_status[FI_BUS] && !live;
  endproperty
  a_cdb_bad_phase: assert property (p_cdb_bad_phase)
    else $error("illegal phase after cdb not flagged");

  property p_pause4;
    live && s_reg.code == CODE_CDB_DONE && pause_req && !start_req
      |=> s_reg.error_irq_status[EI_HALT] && seq_halt ##1 !seq_halt;
  endproperty
  a_pause4: assert property (p_pause4)
    else $error("pause in code 4 did not halt");

  property p_parity;
    live && s_reg.code == CODE_DATA && parity_err && !pause_req &&
      !start_req |=> s_reg.error_irq_status[EI_PE] && s_reg.error_irq_status[EI_HALT] &&
      seq_code == CODE_DATA;
  endproperty
  a_parity: assert property (p_parity)
    else $error("parity error not reported");

  property p_pause5;
    live && s_reg.code == CODE_DATA && pause_req && !start_req
      |=> !live && s_reg.error_irq_status[EI_HALT];
  endproperty
  a_pause5: assert property (p_pause5)
    else $error("pause in code 5 did not stop");

  property p_sdp;
    live && phase_new && ev.ok && ev.next_code == CODE_SDP &&
      s_reg.code != CODE_RESEL && !start_req && !pause_req &&
      !parity_err && !data_done |=> s_reg.ptr_saved && seq_code == CODE_SDP;
  endproperty
  a_sdp: assert property (p_sdp)
    else $error("pointer saved bit missing in code 6");

  property p_cc_leave;
    live && s_reg.code == CODE_CC && target_gone && !start_req
      |=> s_reg.functional_irq_status[FI_FC] && !live;
  endproperty
  a_cc_leave: assert property (p_cc_leave)
    else $error("no function done after disconnect");

  property p_picked;
    live && s_reg.code == CODE_TGT_GONE && picked_as_target &&
      !pause_req && !start_req |=> s_reg.functional_irq_status[FI_SEL];
  endproperty
  a_picked: assert property (p_picked)
    else $error("selection as target not flagged");

  property p_resel_other;
    live && s_reg.code == CODE_TGT_GONE && resel_seen &&
      !picked_as_target && !pause_req && !start_req &&
      resel_id != s_reg.tid |=> s_reg.functional_irq_status[FI_RSL] && !live;
  endproperty
  a_resel_other: assert property (p_resel_other)
    else $error("other target reselect not flagged");

  property p_wait;
    s_leave_nohold ##1 s_parked_quiet [*2] |-> live &&
      seq_code == CODE_TGT_GONE && !s_reg.functional_irq_status[FI_DIS];
  endproperty
  a_wait: assert property (p_wait)
    else $error("no-hold disconnect did not wait in code 8");

  property p_hold_leave;
    live && s_reg.code == CODE_DISC_MSG && target_gone && s_reg.hold &&
      !start_req && !pause_req |=> s_reg.functional_irq_status[FI_DIS] &&
      seq_code == CODE_TGT_GONE;
  endproperty
  a_hold_leave: assert property (p_hold_leave)
    else $error("hold disconnect not flagged");

  property p_code_hold;
    !live && !start_req |=> $stable(seq_code);
  endproperty
  a_code_hold: assert property (p_code_hold)
    else $error("code changed while idle");
endmodule

/* verif/swx_tgt_model.sv */
// Purpose: behavioural scsi target seen through the bus core event lines
// Assumes: pulses last one sys_clk cycle, set just after a rising edge
// Notes: idle data lines show the inverse of their last value
module swx_tgt_model
  import swx_pkg::*;
#(
  parameter int ID_W = 3
) (
  // clock
  input wire logic sys_clk,
  // bus core events
  output logic cdb_done,
  output logic cdb_len_err,
  output logic phase_new,
  output logic [2:0] phase_kind,
  output logic [7:0] msg_byte,
  output logic tc_zero,
  output logic data_done,
  output logic parity_err,
  output logic target_gone,
  output logic resel_seen,
  output logic [ID_W-1:0] resel_id,
  output logic picked_as_target
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    {cdb_done, cdb_len_err, phase_new, data_done, parity_err} = '0;
    {target_gone, resel_seen, picked_as_target} = '0;
    tc_zero = 1'b1;
    phase_kind = 3'h2;
    msg_byte = 8'h5a;
    resel_id = '1;
  end

  // one-cycle event: 0 cdb,1 len,2 data,3 parity,4 gone,5 picked
  task automatic pulse(input int which);
    @(posedge sys_clk);
    case (which)
      0: cdb_done <= 1'b1;
      1: cdb_len_err <= 1'b1;
      2: data_done <= 1'b1;
      3: parity_err <= 1'b1;
      4: target_gone <= 1'b1;
      default: picked_as_target <= 1'b1;
    endcase
    @(posedge sys_clk);
    {cdb_done, cdb_len_err, data_done, parity_err} <= '0;
    {target_gone, picked_as_target} <= '0;
  endtask

  // lines are inverted after use so stale values never look valid
  task automatic phase(input logic [2:0] k, input logic [7:0] m);
    @(posedge sys_clk);
    phase_new <= 1'b1;
    phase_kind <= k;
    msg_byte <= m;
    @(posedge sys_clk);
    phase_new <= 1'b0;
    phase_kind <= ~k;
    msg_byte <= ~m;
  endtask

  task automatic resel(input logic [ID_W-1:0] id);
    @(posedge sys_clk);
    resel_seen <= 1'b1;
    resel_id <= id;
    @(posedge sys_clk);
    resel_seen <= 1'b0;
    resel_id <= ~id;
  endtask

  task automatic set_tc(input logic v);
    @(posedge sys_clk);
    tc_zero <= v;
  endtask
endmodule

/* verif/swx_term_tb.sv */
// Purpose: self-checking bench for the termination sequencer
// Assumes: apb master waits on pready; target model drives events
// Notes: flags are cleared between scenarios by write-one-to-clear
module swx_term_tb
  import swx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int EV_CDB = 0;
  localparam int EV_LEN = 1;
  localparam int EV_DATA = 2;
  localparam int EV_PAR = 3;
  localparam int EV_GONE = 4;
  localparam int EV_PICK = 5;
  logic sys_clk = 1'b0;
  logic reset_n;
  logic psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, seq_active, seq_halt;
  logic [3:0] seq_code;
  logic cdb_done, cdb_len_err, phase_new, tc_zero, data_done;
  logic parity_err, target_gone, resel_seen, picked_as_target;
  logic [2:0] phase_kind, resel_id;
  logic [7:0] msg_byte;
  int error_cnt;
  int comparisons;

  always #25 sys_clk = ~sys_clk;

  swx_term #(.ID_W(3)) dut (.sys_clk(sys_clk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cdb_done(cdb_done), .cdb_len_err(cdb_len_err), .phase_new(phase_new),
    .phase_kind(phase_kind), .msg_byte(msg_byte), .tc_zero(tc_zero),
    .data_done(data_done), .parity_err(parity_err),
    .target_gone(target_gone), .resel_seen(resel_seen),
    .resel_id(resel_id), .picked_as_target(picked_as_target),
    .seq_active(seq_active), .seq_code(seq_code), .seq_halt(seq_halt));

  swx_tgt_model #(.ID_W(3)) tgt (.sys_clk(sys_clk), .cdb_done(cdb_done),
    .cdb_len_err(cdb_len_err), .phase_new(phase_new),
    .phase_kind(phase_kind), .msg_byte(msg_byte), .tc_zero(tc_zero),
    .data_done(data_done), .parity_err(parity_err),
    .target_gone(target_gone), .resel_seen(resel_seen),
    .resel_id(resel_id), .picked_as_target(picked_as_target));

  task automatic complete_run();
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // status pins settle after the launching edge, so look at the falling one
  task automatic pins_are(input logic h, input logic a, input logic [3:0] c);
    @(negedge sys_clk);
    chk({26'h0, seq_halt, seq_active, seq_code}, {26'h0, h, a, c});
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 64) chk(32'h0, 32'h1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic reg_is(input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r & m, x);
  endtask

  task automatic code_is(input logic [3:0] c);
    reg_is(OFF_STAT, 32'h0000000f, {28'h0, c});
  endtask

  // clear sticky flags first so each scenario sees only its own
  task automatic start(input logic hold, input logic dir);
    wr(OFF_FUNC, 32'h0000001f);
    wr(OFF_ERR, 32'h00000007);
    wr(OFF_CTRL, {21'h0, 3'h2, 4'h1, dir, hold, 2'b01});
  endtask

  task automatic to_data();
    start(1'b0, 1'b1);
    tgt.pulse(EV_CDB);
    tgt.set_tc(1'b0);
    tgt.phase(PH_DATA_IN, 8'h00);
  endtask

  task automatic to_parked(input logic hold);
    start(hold, 1'b1);
    tgt.pulse(EV_CDB);
    tgt.phase(PH_MSG_IN, MSG_DISC);
    tgt.pulse(EV_GONE);
  endtask

  task automatic t_reset();
    logic [31:0] r;
    logic e;
    code_is(CODE_NONE);
    reg_is(OFF_FUNC, 32'h1f, 32'h0);
    reg_is(OFF_ERR, 32'h7, 32'h0);
    apb(1'b0, 8'h40, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
  endtask

  task automatic t_early();
    start(1'b0, 1'b1);
    tgt.pulse(EV_LEN);
    reg_is(OFF_FUNC, 32'h1f, 32'h1);
    reg_is(OFF_ERR, 32'h7, 32'h1);
    code_is(CODE_CDB_START);
    start(1'b0, 1'b1);
    tgt.pulse(EV_CDB);
    wr(OFF_CTRL, 32'h2);
    pins_are(1'b1, 1'b0, CODE_CDB_DONE);
    reg_is(OFF_ERR, 32'h7, 32'h1);
    code_is(CODE_CDB_DONE);
    start(1'b0, 1'b1);
    tgt.pulse(EV_CDB);
    tgt.set_tc(1'b0);
    tgt.phase(PH_DATA_OUT, 8'h00);
    reg_is(OFF_FUNC, 32'h1f, 32'h1);
    code_is(CODE_CDB_DONE);
  endtask

  task automatic t_flow();
    to_data();
    pins_are(1'b0, 1'b1, CODE_DATA);
    code_is(CODE_DATA);
    tgt.pulse(EV_DATA);
    code_is(CODE_DATA_END);
    tgt.set_tc(1'b1);
    tgt.phase(PH_STATUS, 8'h00);
    code_is(CODE_STATUS);
    tgt.phase(PH_MSG_IN, MSG_CMD_DONE);
    code_is(CODE_CC);
    reg_is(OFF_FUNC, 32'h1f, 32'h0);
    tgt.pulse(EV_GONE);
    reg_is(OFF_FUNC, 32'h1f, 32'h2);
  endtask

  task automatic t_data_stops();
    to_data();
    tgt.pulse(EV_PAR);
    reg_is(OFF_ERR, 32'h7, 32'h3);
    code_is(CODE_DATA);
    to_data();
    wr(OFF_CTRL, 32'h2);
    pins_are(1'b1, 1'b0, CODE_DATA);
    reg_is(OFF_ERR, 32'h7, 32'h1);
    code_is(CODE_DATA);
    to_data();
    tgt.phase(PH_MSG_IN, MSG_SDP);
    reg_is(OFF_STAT, 32'h11f, 32'h116);
    tgt.phase(PH_MSG_IN, MSG_DISC);
    code_is(CODE_DISC_MSG);
    tgt.phase(PH_STATUS, 8'h00);
    reg_is(OFF_FUNC, 32'h1f, 32'h1);
  endtask

  task automatic t_parked();
    to_parked(1'b1);
    code_is(CODE_TGT_GONE);
    reg_is(OFF_FUNC, 32'h1f, 32'h10);
    tgt.resel(3'h1);
    reg_is(OFF_FUNC, 32'h08, 32'h08);
    to_parked(1'b1);
    tgt.pulse(EV_PICK);
    reg_is(OFF_FUNC, 32'h1f, 32'h14);
    pins_are(1'b0, 1'b0, CODE_TGT_GONE);
    to_parked(1'b0);
    reg_is(OFF_FUNC, 32'h1f, 32'h0);
    tgt.resel(3'h2);
    reg_is(OFF_FUNC, 32'h1f, 32'h08);
    code_is(CODE_TGT_GONE);
    to_parked(1'b0);
    tgt.resel(3'h1);
    code_is(CODE_RESEL);
    tgt.phase(PH_MSG_IN, 8'h85);
    reg_is(OFF_ERR, 32'h7, 32'h4);
    reg_is(OFF_LUN, 32'h7, 32'h5);
  endtask

  task automatic t_linked();
    to_parked(1'b0);
    tgt.resel(3'h1);
    tgt.phase(PH_MSG_IN, 8'h82);
    code_is(CODE_ID_OK);
    tgt.phase(PH_MSG_IN, MSG_RESTORE);
    code_is(CODE_ID_OK);
    tgt.set_tc(1'b1);
    tgt.phase(PH_STATUS, 8'h00);
    code_is(CODE_STATUS);
    tgt.phase(PH_MSG_IN, MSG_LINKED);
    code_is(CODE_LCC);
    reg_is(OFF_FUNC, 32'h1f, 32'h2);
    tgt.phase(PH_STATUS, 8'h00);
    reg_is(OFF_FUNC, 32'h1f, 32'h3);
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    $display("[ERR] %0t: watchdog expired", $time);
    complete_run();
  end

  initial begin
    reset_n <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 8'h00;
    pwdata <= 32'h0000_0000;
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_reset();
    t_early();
    t_flow();
    t_data_stops();
    t_parked();
    t_linked();
    complete_run();
  end
endmodule
